// ### core/undef_abort_pkg.sv
// Package of constants for the undefined-decode and abort-restore unit
package undef_abort_pkg;
  localparam int          INSTR_W          = 32;
  localparam int          HALF_W           = 16;
  localparam int          REG_IDX_W        = 4;
  // Undefined space: bits 27:25 == 3'b011 with bit 4 set
  localparam int          UNDEF_HI         = 27;
  localparam int          UNDEF_LO         = 25;
  localparam logic [2:0]  UNDEF_FIELD      = 3'h3;
  localparam int          UNDEF_BIT        = 4;
  // Coprocessor numbers handled inside the core
  localparam logic [3:0]  SYSCTL_CP_NUM    = 4'hf;
  localparam logic [3:0]  DEBUG_CP_NUM     = 4'he;
  // Offset added to instruction address when the pc is stored
  localparam logic [31:0] PC_STORE_OFFSET  = 32'h0000000c;
  // Processor modes: user mode is the only unprivileged one
  localparam logic [4:0]  MODE_USER        = 5'h10;
  localparam logic [31:0] RESET_WORD       = 32'h00000000;
  localparam logic [3:0]  PC_INDEX         = 4'hf;
  // Pipeline stage codes, one-hot
  typedef enum logic [4:0] {
    ST_FETCH  = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_EXEC   = 5'b00100,
    ST_MEM    = 5'b01000,
    ST_WB     = 5'b10000
  } stage_e;
endpackage

// ### core/undef_decode_abort_restore.sv
// Undefined-instruction decode, base-restore on data abort and pc-store value
`timescale 1ns/1ps
module undef_decode_abort_restore (
  input  wire logic                                 sys_clk,        // Core clock
  input  wire logic                                 srst,           // Sync reset
  input  wire logic                                 dec_valid,      // Decode holds an instr
  input  wire logic [undef_abort_pkg::INSTR_W-1:0]  dec_instr,      // Instr word (16b in low)
  input  wire logic [undef_abort_pkg::INSTR_W-1:0]  dec_addr,       // Instr address
  input  wire logic                                 dec_half_set,   // 16-bit set selected
  input  wire logic [4:0]                           cpu_mode,       // Current processor mode
  input  wire logic [undef_abort_pkg::INSTR_W-1:0]  base_value,     // Base reg read at decode
  input  wire logic                                 mem_abort,      // Abort for instr in mem
  output logic                                      undef_trap,     // Undefined exception
  output logic                                      abort_trap,     // Data abort exception
  output logic                                      mem_suppress,   // Kill the memory access
  output logic                                      base_restore,   // Write back saved base
  output logic [undef_abort_pkg::REG_IDX_W-1:0]     base_idx,       // Base register index
  output logic [undef_abort_pkg::INSTR_W-1:0]       base_old,       // Saved base value
  output logic [undef_abort_pkg::INSTR_W-1:0]       pc_store_val,   // Value stored for pc
  output logic                                      cp_move_valid,  // Coproc move to issue
  output logic                                      cp_move_read    // Move from coprocessor
);

  import undef_abort_pkg::*;

  // ----------------------------------------------------------------
  // Field views of the word in decode
  // ----------------------------------------------------------------
  logic [INSTR_W-1:0] iw;           // Word in its 32-bit view
  logic [HALF_W-1:0]  hw;           // Low half in its 16-bit view
  logic [3:0]         cp_num;       // Coprocessor number field
  logic               cp_internal;  // Aimed at a coprocessor inside the core
  logic               privileged;   // Any mode but user

  // Slices for the 32-bit and 16-bit decoders
  assign iw          = dec_instr;
  assign hw          = dec_instr[HALF_W-1:0];
  assign cp_num      = dec_instr[11:8];
  assign cp_internal = (cp_num == SYSCTL_CP_NUM) || (cp_num == DEBUG_CP_NUM);
  assign privileged  = (cpu_mode != MODE_USER);

  // ----------------------------------------------------------------
  // 32-bit set classification
  // ----------------------------------------------------------------
  logic w_undef_space;   // Always-undefined space
  logic w_arith_undef;   // Unused corner of the multiply space
  logic w_ctrl_space;    // Control extension space
  logic w_ctrl_ok;       // Status moves and branch-exchange
  logic w_ls_ext;        // Bits 27:25 zero with bits 7 and 4 set
  logic w_ls_undef;      // Unused load/store extension encodings
  logic w_cp_ext;        // Coprocessor extension space
  logic w_cp_data;       // Coprocessor data operation
  logic w_cp_move;       // Register move to or from a coprocessor
  logic w_cp_xfer;       // Coprocessor load or store
  logic w_cp_trap;       // Coprocessor access refused by the core
  logic w_single;        // Single word or byte transfer
  logic w_half_xfer;     // Halfword and signed transfers
  logic w_multi;         // Multiple-register transfer
  logic w_swap;          // Swap
  logic w_undef;         // Any undefined reason
  logic w_access;        // Goes to memory
  logic w_wb;            // Updates its base register
  logic w_pc_store;      // Writes the pc to memory

  // Undefined space and extension spaces
  assign w_undef_space = (iw[UNDEF_HI:UNDEF_LO] == UNDEF_FIELD) && iw[UNDEF_BIT];
  assign w_arith_undef = (iw[27:24] == 4'h0) && (iw[7:4] == 4'h9)
                         && (iw[23:22] == 2'h1);
  assign w_ls_ext      = (iw[27:25] == 3'h0) && iw[7] && iw[4];
  assign w_ls_undef    = w_ls_ext
                         && (((iw[6:5] != 2'h0) && !iw[20] && iw[6])
                             || ((iw[6:5] == 2'h0) && iw[24]
                                 && (iw[23] || (iw[21:20] != 2'h0))));
  assign w_ctrl_space  = (iw[27:26] == 2'h0) && (iw[24:23] == 2'h2) && !iw[20]
                         && !(!iw[25] && iw[7] && iw[4]);
  assign w_ctrl_ok     = (!iw[25] && (iw[7:4] == 4'h0))
                         || (iw[25] && iw[21])
                         || (!iw[25] && (iw[22:21] == 2'h1) && (iw[7:4] == 4'h1));
  assign w_cp_ext      = (iw[27:23] == 5'h18) && !iw[21];

  // Coprocessor classes; core coprocessors only take register moves
  assign w_cp_data     = (iw[27:24] == 4'he) && !iw[4];
  assign w_cp_move     = (iw[27:24] == 4'he) && iw[4];
  assign w_cp_xfer     = (iw[27:25] == 3'h6) && !w_cp_ext;
  assign w_cp_trap     = ((w_cp_data || w_cp_xfer) && cp_internal)
                         || (w_cp_move && (cp_num == SYSCTL_CP_NUM) && !privileged);

  // Memory classes
  assign w_single      = (iw[27:26] == 2'h1) && !w_undef_space;
  assign w_half_xfer   = w_ls_ext && (iw[6:5] != 2'h0) && !w_ls_undef;
  assign w_multi       = (iw[27:25] == 3'h4);
  assign w_swap        = w_ls_ext && (iw[6:5] == 2'h0) && iw[24] && !w_ls_undef;

  // Summary of the 32-bit word
  assign w_undef       = w_undef_space || w_arith_undef || (w_ctrl_space && !w_ctrl_ok)
                         || w_ls_undef || w_cp_ext || w_cp_trap;
  assign w_access      = w_single || w_half_xfer || w_multi || w_swap
                         || (w_cp_xfer && !cp_internal);
  assign w_wb          = ((w_single || w_half_xfer) && (!iw[24] || iw[21]))
                         || ((w_multi || w_cp_xfer) && iw[21]);
  assign w_pc_store    = !iw[20] && ((w_single && (iw[15:12] == PC_INDEX))
                                     || (w_multi && iw[PC_INDEX]));

  // ----------------------------------------------------------------
  // 16-bit set classification
  // ----------------------------------------------------------------
  logic       h_undef;   // Undefined 16-bit encoding
  logic       h_single;  // Single transfers, no base update
  logic       h_multi;   // Multiple transfer with base update
  logic       h_stack;   // Push or pop through the stack pointer
  logic [3:0] h_base;    // Base register of a 16-bit transfer

  // Reserved corners of the compressed set
  assign h_undef  = (hw[15:8] == 8'hde) || (hw[15:11] == 5'h1d)
                    || ((hw[15:12] == 4'hb)
                        && !((hw[11:8] == 4'h0) || (hw[10:9] == 2'h2)));
  assign h_single = (hw[15:12] >= 4'h5) && (hw[15:12] <= 4'h9);
  assign h_multi  = (hw[15:12] == 4'hc);
  assign h_stack  = (hw[15:12] == 4'hb) && (hw[10:9] == 2'h2);
  // Stack pointer is register 13
  assign h_base   = h_multi ? {1'b0, hw[10:8]} : 4'hd;

  // ----------------------------------------------------------------
  // Selection by the active instruction set
  // ----------------------------------------------------------------
  logic                 d_undef;     // Word decodes as undefined
  logic                 d_access;    // Word reaches memory
  logic                 d_wb;        // Word updates its base
  logic [REG_IDX_W-1:0] d_base_idx;  // Base register index
  logic                 d_pc_store;  // Word stores the pc
  logic                 d_move;      // Allowed move to a core coprocessor

  // Only the selected set is decoded
  assign d_undef    = dec_half_set ? h_undef : w_undef;
  assign d_access   = (dec_half_set ? (h_single || h_multi || h_stack) : w_access)
                      && !d_undef;
  assign d_wb       = dec_half_set ? (h_multi || h_stack) : w_wb;
  assign d_base_idx = dec_half_set ? h_base : iw[19:16];
  assign d_pc_store = !dec_half_set && w_pc_store;
  assign d_move     = !dec_half_set && w_cp_move && cp_internal && !w_cp_trap;

  // ----------------------------------------------------------------
  // Decode to execute: stage registers and decode results
  // ----------------------------------------------------------------
  logic                 ex_undef_q;       // Undefined word in execute
  logic                 ex_undef_d;
  logic                 ex_access_q;      // Live access in execute
  logic                 ex_access_d;
  logic                 ex_wb_q;          // Base update in execute
  logic                 ex_wb_d;
  logic [REG_IDX_W-1:0] ex_idx_q;         // Base index in execute
  logic [REG_IDX_W-1:0] ex_idx_d;
  logic [INSTR_W-1:0]   ex_base_q;        // Base value before the word
  logic [INSTR_W-1:0]   ex_base_d;
  logic                 undef_trap_q;     // Undefined exception pulse
  logic                 undef_trap_d;
  logic                 cp_move_valid_q;  // Move issue pulse
  logic                 cp_move_valid_d;
  logic                 cp_move_read_q;   // Move direction
  logic                 cp_move_read_d;
  logic [INSTR_W-1:0]   pc_store_val_q;   // Value for a stored pc
  logic [INSTR_W-1:0]   pc_store_val_d;

  // Next values on leaving decode
  always_comb begin
    ex_undef_d      = dec_valid && d_undef;
    ex_access_d     = dec_valid && d_access;
    ex_wb_d         = d_wb;
    ex_idx_d        = d_base_idx;
    ex_base_d       = base_value;
    undef_trap_d    = dec_valid && d_undef;
    cp_move_valid_d = dec_valid && d_move;
    cp_move_read_d  = dec_valid && d_move && iw[20];
    pc_store_val_d  = pc_store_val_q;
    if (dec_valid && d_pc_store) begin
      pc_store_val_d = dec_addr + PC_STORE_OFFSET;
    end
    if (srst) begin
      ex_undef_d      = 1'b0;
      ex_access_d     = 1'b0;
      ex_wb_d         = 1'b0;
      ex_idx_d        = RESET_WORD[REG_IDX_W-1:0];
      ex_base_d       = RESET_WORD;
      undef_trap_d    = 1'b0;
      cp_move_valid_d = 1'b0;
      cp_move_read_d  = 1'b0;
      pc_store_val_d  = RESET_WORD;
    end
  end

  // Decode-edge registers
  always_ff @(posedge sys_clk) begin
    ex_undef_q      <= ex_undef_d;
    ex_access_q     <= ex_access_d;
    ex_wb_q         <= ex_wb_d;
    ex_idx_q        <= ex_idx_d;
    ex_base_q       <= ex_base_d;
    undef_trap_q    <= undef_trap_d;
    cp_move_valid_q <= cp_move_valid_d;
    cp_move_read_q  <= cp_move_read_d;
    pc_store_val_q  <= pc_store_val_d;
  end

  // ----------------------------------------------------------------
  // Execute to memory: access kill and saved base
  // ----------------------------------------------------------------
  logic                 mem_valid_q;     // Live access in memory
  logic                 mem_valid_d;
  logic                 mem_wb_q;        // Base update in memory
  logic                 mem_wb_d;
  logic [REG_IDX_W-1:0] mem_idx_q;       // Base index in memory
  logic [REG_IDX_W-1:0] mem_idx_d;
  logic [INSTR_W-1:0]   mem_base_q;      // Saved base in memory
  logic [INSTR_W-1:0]   mem_base_d;
  logic                 mem_suppress_q;  // Kill pulse for the access
  logic                 mem_suppress_d;

  // Undefined words never enter memory, so a late abort is ignored
  always_comb begin
    mem_valid_d    = ex_access_q;
    mem_wb_d       = ex_wb_q;
    mem_idx_d      = ex_idx_q;
    mem_base_d     = ex_base_q;
    mem_suppress_d = ex_undef_q;
    if (srst) begin
      mem_valid_d    = 1'b0;
      mem_wb_d       = 1'b0;
      mem_idx_d      = RESET_WORD[REG_IDX_W-1:0];
      mem_base_d     = RESET_WORD;
      mem_suppress_d = 1'b0;
    end
  end

  // Execute-edge registers
  always_ff @(posedge sys_clk) begin
    mem_valid_q    <= mem_valid_d;
    mem_wb_q       <= mem_wb_d;
    mem_idx_q      <= mem_idx_d;
    mem_base_q     <= mem_base_d;
    mem_suppress_q <= mem_suppress_d;
  end

  // ----------------------------------------------------------------
  // Memory to write-back: abort and base restore
  // ----------------------------------------------------------------
  logic                 abort_trap_q;    // Data abort pulse
  logic                 abort_trap_d;
  logic                 base_restore_q;  // Restore pulse
  logic                 base_restore_d;
  logic [REG_IDX_W-1:0] base_idx_q;      // Index to restore, held
  logic [REG_IDX_W-1:0] base_idx_d;
  logic [INSTR_W-1:0]   base_old_q;      // Value to restore, held
  logic [INSTR_W-1:0]   base_old_d;

  // Write-back puts the old base back instead of the updated one
  always_comb begin
    abort_trap_d   = mem_valid_q && mem_abort;
    base_restore_d = mem_valid_q && mem_abort && mem_wb_q;
    base_idx_d     = base_idx_q;
    base_old_d     = base_old_q;
    if (mem_valid_q && mem_abort && mem_wb_q) begin
      base_idx_d = mem_idx_q;
      base_old_d = mem_base_q;
    end
    if (srst) begin
      abort_trap_d   = 1'b0;
      base_restore_d = 1'b0;
      base_idx_d     = RESET_WORD[REG_IDX_W-1:0];
      base_old_d     = RESET_WORD;
    end
  end

  // Memory-edge registers
  always_ff @(posedge sys_clk) begin
    abort_trap_q   <= abort_trap_d;
    base_restore_q <= base_restore_d;
    base_idx_q     <= base_idx_d;
    base_old_q     <= base_old_d;
  end

  // ----------------------------------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign undef_trap    = undef_trap_q;
  assign abort_trap    = abort_trap_q;
  assign mem_suppress  = mem_suppress_q;
  assign base_restore  = base_restore_q;
  assign base_idx      = base_idx_q;
  assign base_old      = base_old_q;
  assign pc_store_val  = pc_store_val_q;
  assign cp_move_valid = cp_move_valid_q;
  assign cp_move_read  = cp_move_read_q;

endmodule

// ### verif/undef_chk_assertions.sv
// Concurrent checks on the ports of the undefined-decode and abort-restore unit
`timescale 1ns/1ps
module undef_chk (
  input wire logic        sys_clk,        // Core clock
  input wire logic        srst,           // Sync reset
  input wire logic        dec_valid,      // Word in decode
  input wire logic [31:0] dec_instr,      // Word
  input wire logic [31:0] dec_addr,       // Word address
  input wire logic        dec_half_set,   // 16-bit set
  input wire logic [4:0]  cpu_mode,       // Mode
  input wire logic        undef_trap,     // Undefined exception
  input wire logic        abort_trap,     // Abort exception
  input wire logic        mem_suppress,   // Access kill
  input wire logic        base_restore,   // Restore pulse
  input wire logic [31:0] pc_store_val,   // Stored pc value
  input wire logic        cp_move_valid,  // Move issue
  input wire logic        cp_move_read    // Move direction
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_undef_space: assert property (
    dec_valid && !dec_half_set && dec_instr[27:25] == 3'h3 && dec_instr[4] |=> undef_trap)
    else $error("undefined space not trapped");
  a_arith_ext: assert property (
    dec_valid && !dec_half_set && dec_instr[27:24] == 4'h0 && dec_instr[7:4] == 4'h9
    && dec_instr[23:22] == 2'h1 |=> undef_trap)
    else $error("arithmetic extension not trapped");
  a_restore_abort: assert property (
    base_restore |-> abort_trap)
    else $error("restore without abort");
  a_pc_store_val: assert property (
    dec_valid && !dec_half_set && dec_instr[27:26] == 2'h1 && !dec_instr[20]
    && dec_instr[15:12] == 4'hf && !(dec_instr[25] && dec_instr[4])
    |=> pc_store_val == $past(dec_addr) + 32'h0000000c)
    else $error("stored pc value wrong");
  a_suppress_stage: assert property (
    mem_suppress |-> $past(undef_trap))
    else $error("suppress out of stage order");
  a_half_undef: assert property (
    dec_valid && dec_half_set && dec_instr[15:8] == 8'hde |=> undef_trap)
    else $error("16-bit undefined not trapped");
  a_move_read: assert property (
    cp_move_valid |-> cp_move_read == $past(dec_instr[20]))
    else $error("move direction wrong");
  a_trap_no_move: assert property (
    undef_trap |-> !cp_move_valid)
    else $error("trapped move issued");
  a_user_sysctl: assert property (
    dec_valid && !dec_half_set && cpu_mode == 5'h10 && dec_instr[27:24] == 4'he
    && dec_instr[4] && dec_instr[11:8] == 4'hf |=> undef_trap && !cp_move_valid)
    else $error("user move to system coprocessor not trapped");
  a_undef_no_abort: assert property (
    dec_valid && !dec_half_set && dec_instr[27:25] == 3'h3 && dec_instr[4]
    |-> ##2 mem_suppress ##1 !abort_trap)
    else $error("undefined word reached memory");
endmodule

bind undef_decode_abort_restore undef_chk chk (
  .sys_clk       (sys_clk),
  .srst          (srst),
  .dec_valid     (dec_valid),
  .dec_instr     (dec_instr),
  .dec_addr      (dec_addr),
  .dec_half_set  (dec_half_set),
  .cpu_mode      (cpu_mode),
  .undef_trap    (undef_trap),
  .abort_trap    (abort_trap),
  .mem_suppress  (mem_suppress),
  .base_restore  (base_restore),
  .pc_store_val  (pc_store_val),
  .cp_move_valid (cp_move_valid),
  .cp_move_read  (cp_move_read)
);

// ### verif/abort_src.sv
// Memory-side model that raises the data abort while the word is in memory
`timescale 1ns/1ps
module abort_src (
  input  wire logic sys_clk,   // Core clock
  input  wire logic req,       // Abort wanted for the word in decode
  output logic      mem_abort  // Abort during the memory stage
);
  logic req_ex_q = 1'b0;  // Request while the word is in execute

  // Two edges of delay line the abort up with the memory stage
  initial mem_abort = 1'b0;
  always @(posedge sys_clk) begin
    req_ex_q  <= req;
    mem_abort <= req_ex_q;
  end
endmodule

// ### verif/tb_top.sv
// Testbench: scenario tasks for the undefined-decode and abort-restore unit
`timescale 1ns/1ps
module tb_top;
  import undef_abort_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        dec_valid = 1'b0;
  logic        dec_half_set = 1'b0;
  logic        req = 1'b0;
  logic [4:0]  cpu_mode = 5'h13;
  logic [31:0] dec_instr = '0;
  logic [31:0] dec_addr = '0;
  logic [31:0] base_value = '0;
  logic        mem_abort, undef_trap, abort_trap, mem_suppress, base_restore;
  logic        cp_move_valid, cp_move_read;
  logic [3:0]  base_idx;
  logic [31:0] base_old, pc_store_val, s_pc;
  logic        s_undef, s_mv, s_rd, s_sup, s_abt, s_rst;
  int          error_cnt = 0;
  int          n_checks = 0;

  undef_decode_abort_restore dut (
    .sys_clk(sys_clk), .srst(srst), .dec_valid(dec_valid), .dec_instr(dec_instr),
    .dec_addr(dec_addr), .dec_half_set(dec_half_set), .cpu_mode(cpu_mode),
    .base_value(base_value), .mem_abort(mem_abort), .undef_trap(undef_trap),
    .abort_trap(abort_trap), .mem_suppress(mem_suppress), .base_restore(base_restore),
    .base_idx(base_idx), .base_old(base_old), .pc_store_val(pc_store_val),
    .cp_move_valid(cp_move_valid), .cp_move_read(cp_move_read));
  abort_src model (.sys_clk(sys_clk), .req(req), .mem_abort(mem_abort));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // One word through decode, execute and memory; results sampled per stage
  task automatic issue(input logic [31:0] i, input logic [31:0] a, input logic h,
                       input logic ab);
    @(negedge sys_clk);
    dec_valid = 1'b1;
    dec_instr = i;
    dec_addr = a;
    dec_half_set = h;
    req = ab;
    base_value = ~i;
    @(negedge sys_clk);
    s_undef = undef_trap;
    s_mv = cp_move_valid;
    s_rd = cp_move_read;
    s_pc = pc_store_val;
    dec_valid = 1'b0;
    req = 1'b0;
    @(negedge sys_clk);
    s_sup = mem_suppress;
    @(negedge sys_clk);
    s_abt = abort_trap;
    s_rst = base_restore;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic t_undef_space;
    issue(32'he6000010, '0, 1'b0, 1'b0);
    chk_bit("undef space", 1'b1, s_undef);
    chk_bit("undef suppress", 1'b1, s_sup);
    issue(32'he6000000, '0, 1'b0, 1'b0);
    chk_bit("reg offset store", 1'b0, s_undef);
    $display("done t_undef_space");
  endtask

  task automatic t_ext_spaces;
    issue(32'he0400090, '0, 1'b0, 1'b0);
    chk_bit("arith ext", 1'b1, s_undef);
    issue(32'he1000010, '0, 1'b0, 1'b0);
    chk_bit("control ext", 1'b1, s_undef);
    issue(32'he00000d0, '0, 1'b0, 1'b0);
    chk_bit("load store ext", 1'b1, s_undef);
    issue(32'hec000000, '0, 1'b0, 1'b0);
    chk_bit("coproc ext", 1'b1, s_undef);
    issue(32'he0000090, '0, 1'b0, 1'b0);
    chk_bit("multiply", 1'b0, s_undef);
    issue(32'he12fff10, '0, 1'b0, 1'b0);
    chk_bit("branch exchange", 1'b0, s_undef);
    issue(32'he1000090, '0, 1'b0, 1'b0);
    chk_bit("swap", 1'b0, s_undef);
    $display("done t_ext_spaces");
  endtask

  task automatic t_abort_restore;
    issue(32'he5b10004, '0, 1'b0, 1'b1);
    chk_bit("abort wb", 1'b1, s_abt);
    chk_bit("restore wb", 1'b1, s_rst);
    chk_word("base idx", 32'h1, {28'h0, base_idx});
    chk_word("base old", ~32'he5b10004, base_old);
    issue(32'he5910004, '0, 1'b0, 1'b1);
    chk_bit("abort no wb", 1'b1, s_abt);
    chk_bit("restore no wb", 1'b0, s_rst);
    issue(32'he5b10004, '0, 1'b0, 1'b0);
    chk_bit("no abort", 1'b0, s_abt);
    issue(32'he8a20003, '0, 1'b0, 1'b1);
    chk_bit("restore multi", 1'b1, s_rst);
    chk_word("multi idx", 32'h2, {28'h0, base_idx});
    $display("done t_abort_restore");
  endtask

  task automatic t_pc_store;
    issue(32'he580f000, 32'h00001000, 1'b0, 1'b0);
    chk_word("pc single", 32'h00001000 + PC_STORE_OFFSET, s_pc);
    issue(32'he8808000, 32'h00002000, 1'b0, 1'b0);
    chk_word("pc multi", 32'h00002000 + PC_STORE_OFFSET, s_pc);
    issue(32'he5801000, 32'h00003000, 1'b0, 1'b0);
    chk_word("other store", 32'h00002000 + PC_STORE_OFFSET, s_pc);
    $display("done t_pc_store");
  endtask

  task automatic t_coproc;
    issue(32'hee110f10, '0, 1'b0, 1'b0);
    chk_bit("priv read move", 1'b1, s_mv);
    chk_bit("priv read dir", 1'b1, s_rd);
    cpu_mode = MODE_USER;
    issue(32'hee110f10, '0, 1'b0, 1'b0);
    chk_bit("user sysctl trap", 1'b1, s_undef);
    chk_bit("user sysctl move", 1'b0, s_mv);
    issue(32'hee000e10, '0, 1'b0, 1'b0);
    chk_bit("user debug move", 1'b1, s_mv);
    chk_bit("user debug dir", 1'b0, s_rd);
    chk_bit("user debug trap", 1'b0, s_undef);
    cpu_mode = 5'h13;
    issue(32'hee000f00, '0, 1'b0, 1'b0);
    chk_bit("sysctl data op", 1'b1, s_undef);
    issue(32'hed800f00, '0, 1'b0, 1'b0);
    chk_bit("sysctl store", 1'b1, s_undef);
    $display("done t_coproc");
  endtask

  task automatic t_half_set;
    issue(32'h0000de00, '0, 1'b1, 1'b0);
    chk_bit("half undef", 1'b1, s_undef);
    issue(32'h00004770, '0, 1'b1, 1'b0);
    chk_bit("half defined", 1'b0, s_undef);
    issue(32'h0000b500, '0, 1'b1, 1'b1);
    chk_bit("half push restore", 1'b1, s_rst);
    chk_word("half push idx", 32'hd, {28'h0, base_idx});
    $display("done t_half_set");
  endtask

  task automatic t_both;
    issue(32'he6000010, '0, 1'b0, 1'b1);
    chk_bit("both undef", 1'b1, s_undef);
    chk_bit("both suppress", 1'b1, s_sup);
    chk_bit("both no abort", 1'b0, s_abt);
    $display("done t_both");
  endtask

  task automatic t_midrun_reset;
    @(negedge sys_clk);
    srst = 1'b1;
    dec_valid = 1'b1;
    dec_instr = 32'he6000010;
    @(negedge sys_clk);
    chk_bit("reset undef", 1'b0, undef_trap);
    chk_word("reset base old", RESET_WORD, base_old);
    dec_valid = 1'b0;
    @(negedge sys_clk);
    srst = 1'b0;
    issue(32'he6000010, '0, 1'b0, 1'b0);
    chk_bit("after reset undef", 1'b1, s_undef);
    $display("done t_midrun_reset");
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well past the roughly 115 cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    $display("ERROR watchdog exp done got timeout");
    give_verdict;
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    t_undef_space;
    t_ext_spaces;
    t_abort_restore;
    t_pc_store;
    t_coproc;
    t_half_set;
    t_both;
    t_midrun_reset;
    give_verdict;
  end
endmodule
